// ### hdl/spc_port.sv
// Serial port controller: AXI4-Lite registers, queues and shift engine
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps
module spc_port
	import spc_pkg::*;
#(
	parameter int HALF_CYC = SCLK_HALF_CYC
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_b_i,
	input  wire logic [31:0] s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [31:0] s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	input  wire logic        sclk_i,
	output logic             sclk_o,
	output logic             sclk_oe_o,
	input  wire logic        ssel_b_i,
	output logic             ssel_b_o,
	output logic             ssel_b_oe_o,
	input  wire logic        mosi_i,
	output logic             mosi_o,
	output logic             mosi_oe_o,
	input  wire logic        miso_i,
	output logic             miso_o,
	output logic             miso_oe_o
);

	if (HALF_CYC < 2 || HALF_CYC > 255) begin : g_bad_half
		$error("HALF_CYC must lie in 2..255");
	end

	// Unsupported short codes fall back to the shortest frame
	function automatic logic [4:0] frame_bits(input logic [3:0] code);
		frame_bits = (code < FSS_MIN) ? BITS_MIN : {1'b0, code} + 5'h01;
	endfunction

	function automatic logic top_bit(input logic [15:0] sh,
		input logic [3:0] code);
		top_bit = sh[4'(frame_bits(code) - 5'h01)];
	endfunction

	spc_state_s s;
	spc_state_s next_s;
	logic       tx_push;
	logic       tx_pop;
	logic       rx_push;
	logic       rx_pop;
	logic       rx_bit;
	logic       sclk_up;
	logic       sclk_dn;
	logic       half_done;
	logic [15:0] rx_head;

	assign rx_head = s.rxq[s.rx_rd];

	always_comb begin
		next_s = s;
		tx_push = 1'b0;
		tx_pop = 1'b0;
		rx_push = 1'b0;
		rx_pop = 1'b0;
		next_s.sclk_s = {s.sclk_s[1:0], sclk_i};
		next_s.ssel_s = {s.ssel_s[0], ssel_b_i};
		next_s.mosi_s = {s.mosi_s[0], mosi_i};
		next_s.miso_s = {s.miso_s[0], miso_i};
		sclk_up = s.sclk_s[1] && !s.sclk_s[2];
		sclk_dn = !s.sclk_s[1] && s.sclk_s[2];
		half_done = (s.div == 8'(HALF_CYC - 1));
		if (s.loop)
			rx_bit = s.role ? s.miso : s.mosi;
		else
			rx_bit = s.role ? s.mosi_s[1] : s.miso_s[1];

		// Write channel: address and data may arrive in either order
		if (s_axi_awvalid_i && s.awready) begin
			next_s.aw_got = 1'b1;
			next_s.waddr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s.wready) begin
			next_s.w_got = 1'b1;
			next_s.wdata = s_axi_wdata_i[15:0];
			next_s.wstrb = s_axi_wstrb_i[1:0];
		end
		if (s.bvalid && s_axi_bready_i)
			next_s.bvalid = 1'b0;
		if (s.aw_got && s.w_got && !s.bvalid) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OKAY;
			case (s.waddr)
				FRAME_CONFIG_ADDR: if (s.wstrb[0])
					next_s.fss = s.wdata[3:0];
				PORT_CONTROL_ADDR: if (s.wstrb[0]) begin
					next_s.loop = s.wdata[LOOP_BIT];
					next_s.en = s.wdata[EN_BIT];
					next_s.sob = s.wdata[SOB_BIT];
					if (!s.en)
						next_s.role = s.wdata[ROLE_BIT];
				end
				// Write to a full queue is dropped
				DATA_PORT_ADDR: tx_push = (|s.wstrb) && (s.tx_cnt != Q_FULL);
				PORT_STATUS_ADDR: ;
				default: next_s.bresp = RESP_SLVERR;
			endcase
		end

		// Read channel
		if (s.rvalid && s_axi_rready_i)
			next_s.rvalid = 1'b0;
		if (s_axi_arvalid_i && s.arready) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = RESP_OKAY;
			next_s.rdata = '0;
			case (s_axi_araddr_i)
				FRAME_CONFIG_ADDR: next_s.rdata[3:0] = s.fss;
				PORT_CONTROL_ADDR:
					next_s.rdata[3:0] = {s.sob, s.role, s.en, s.loop};
				// pop oldest frame; upper bits stay zero
				DATA_PORT_ADDR: if (s.rx_cnt != '0) begin
					next_s.rdata[15:0] = rx_head;
					rx_pop = 1'b1;
				end
				PORT_STATUS_ADDR: begin
					next_s.rdata[ST_TX_EMPTY] = (s.tx_cnt == '0);
					next_s.rdata[ST_TX_ROOM] = (s.tx_cnt != Q_FULL);
					next_s.rdata[ST_RX_ENTRY] = (s.rx_cnt != '0);
					next_s.rdata[ST_BUSY] =
						(s.eng != SPC_IDLE) || (s.tx_cnt != '0);
				end
				default: next_s.rresp = RESP_SLVERR;
			endcase
		end

		// Shift engine, SPI mode 0: sample on rise, shift on fall
		case (s.eng)
			SPC_IDLE: begin
				next_s.sclk = 1'b0;
				next_s.ssel = 1'b1;
				next_s.rxsh = '0;
				next_s.bitcnt = '0;
				next_s.div = '0;
				// enabled master starts on waiting word
				if (s.en && !s.role && s.tx_cnt != '0) begin
					next_s.shreg = s.txq[s.tx_rd];
					tx_pop = 1'b1;
					next_s.ssel = 1'b0;
					next_s.eng = SPC_RUN;
				end else if (s.en && s.role && !s.ssel_s[1]) begin
					tx_pop = (s.tx_cnt != '0);
					next_s.shreg = tx_pop ? s.txq[s.tx_rd] : 16'h0000;
					next_s.eng = SPC_RUN;
				end
			end
			SPC_RUN: begin
				if (!s.en)
					next_s.eng = SPC_IDLE;
				else if (s.role) begin
					if (s.ssel_s[1])
						next_s.eng = SPC_IDLE;
					else if (sclk_up) begin
						next_s.rxsh = {s.rxsh[14:0], rx_bit};
						next_s.bitcnt = s.bitcnt + 5'h01;
						if (next_s.bitcnt == frame_bits(s.fss)) begin
							rx_push = 1'b1;
							next_s.bitcnt = '0;
						end
					end else if (sclk_dn) begin
						// next queued word follows in order
						if (s.bitcnt == '0) begin
							tx_pop = (s.tx_cnt != '0);
							next_s.shreg = tx_pop ? s.txq[s.tx_rd] : 16'h0000;
							next_s.rxsh = '0;
						end else
							next_s.shreg = {s.shreg[14:0], 1'b0};
					end
				end else begin
					next_s.div = s.div + 8'h01;
					if (half_done) begin
						next_s.div = '0;
						next_s.sclk = !s.sclk;
						if (!s.sclk) begin
							next_s.rxsh = {s.rxsh[14:0], rx_bit};
							next_s.bitcnt = s.bitcnt + 5'h01;
						end else if (s.bitcnt == frame_bits(s.fss)) begin
							rx_push = 1'b1;
							next_s.eng = SPC_END;
						end else
							next_s.shreg = {s.shreg[14:0], 1'b0};
					end
				end
			end
			SPC_END: begin
				next_s.div = s.div + 8'h01;
				// Select rises between frames so the slave can reframe
				if (!s.en || half_done) begin
					next_s.div = '0;
					next_s.ssel = 1'b1;
					next_s.eng = SPC_IDLE;
				end
			end
			default: next_s.eng = SPC_IDLE;
		endcase

		if (tx_push) begin
			next_s.txq[s.tx_wr] = s.wdata;
			next_s.tx_wr = s.tx_wr + 3'h1;
		end
		if (tx_pop)
			next_s.tx_rd = s.tx_rd + 3'h1;
		next_s.tx_cnt = s.tx_cnt + {3'h0, tx_push} - {3'h0, tx_pop};
		// Frame received into a full queue is lost
		if (rx_push && s.rx_cnt != Q_FULL) begin
			next_s.rxq[s.rx_wr] = next_s.rxsh;
			next_s.rx_wr = s.rx_wr + 3'h1;
		end else
			rx_push = 1'b0;
		if (rx_pop)
			next_s.rx_rd = s.rx_rd + 3'h1;
		next_s.rx_cnt = s.rx_cnt + {3'h0, rx_push} - {3'h0, rx_pop};

		// master drives clock, select and MOSI
		next_s.mosi = top_bit(next_s.shreg, s.fss);
		next_s.miso = top_bit(next_s.shreg, s.fss);
		next_s.sclk_oe = next_s.en && !next_s.role;
		next_s.ssel_oe = next_s.en && !next_s.role;
		next_s.mosi_oe = next_s.en && !next_s.role;
		next_s.miso_oe = next_s.en && next_s.role && !next_s.sob &&
			!s.ssel_s[1];
		next_s.awready = !next_s.aw_got && !next_s.bvalid;
		next_s.wready = !next_s.w_got && !next_s.bvalid;
		next_s.arready = !next_s.rvalid;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i)
			s <= '0;
		else
			s <= next_s;
	end

	assign s_axi_awready_o = s.awready;
	assign s_axi_wready_o = s.wready;
	assign s_axi_bresp_o = s.bresp;
	assign s_axi_bvalid_o = s.bvalid;
	assign s_axi_arready_o = s.arready;
	assign s_axi_rdata_o = s.rdata;
	assign s_axi_rresp_o = s.rresp;
	assign s_axi_rvalid_o = s.rvalid;
	assign sclk_o = s.sclk;
	assign sclk_oe_o = s.sclk_oe;
	assign ssel_b_o = s.ssel;
	assign ssel_b_oe_o = s.ssel_oe;
	assign mosi_o = s.mosi;
	assign mosi_oe_o = s.mosi_oe;
	assign miso_o = s.miso;
	assign miso_oe_o = s.miso_oe;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);

	chk_loop_source: assert property (
		s.loop |-> rx_bit == (s.role ? s.miso : s.mosi))
		else $error("loop-back does not use own output");
	chk_off_quiet: assert property (
		!s.en |-> (!sclk_oe_o && !ssel_b_oe_o && !mosi_oe_o &&
			!miso_oe_o) ##1 (s.eng != SPC_RUN))
		else $error("disabled port still on the bus");
	chk_role_frozen: assert property (
		s.en |=> s.role == $past(s.role))
		else $error("role changed while enabled");
	chk_master_pins: assert property (
		s.en && !s.role |-> sclk_oe_o && mosi_oe_o && ssel_b_oe_o &&
			!miso_oe_o)
		else $error("master pin drive wrong");
	chk_slave_block: assert property (
		s.sob && s.role |-> !miso_oe_o && !mosi_oe_o)
		else $error("blocked slave drives a line");
	chk_tx_start: assert property (
		s.eng == SPC_IDLE && s.en && !s.role && s.tx_cnt != '0
		|=> s.eng == SPC_RUN && !ssel_b_o)
		else $error("queued word did not start");
	chk_rx_order: assert property (
		s_axi_arvalid_i && s.arready && s_axi_araddr_i == DATA_PORT_ADDR
		&& s.rx_cnt != '0
		|=> s_axi_rvalid_o && s_axi_rdata_o == {16'h0000, $past(rx_head)})
		else $error("data read not oldest frame");
	chk_entry_flag: assert property (
		s_axi_arvalid_i && s.arready && s_axi_araddr_i == PORT_STATUS_ADDR
		|=> s_axi_rdata_o[ST_RX_ENTRY] == ($past(s.rx_cnt) != '0))
		else $error("entry flag wrong");

endmodule // spc_port

// ### hdl/spc_pkg.sv
// Constants and state types for the serial port controller
package spc_pkg;
	localparam logic [31:0] FRAME_CONFIG_ADDR = 32'h4004_0000;
	localparam logic [31:0] PORT_CONTROL_ADDR = 32'h4004_0004;
	localparam logic [31:0] DATA_PORT_ADDR    = 32'h4004_0008;
	localparam logic [31:0] PORT_STATUS_ADDR  = 32'h4004_000c;
	localparam int LOOP_BIT = 0;
	localparam int EN_BIT   = 1;
	localparam int ROLE_BIT = 2;
	localparam int SOB_BIT  = 3;
	localparam int ST_TX_EMPTY = 0;
	localparam int ST_TX_ROOM  = 1;
	localparam int ST_RX_ENTRY = 2;
	localparam int ST_BUSY     = 4;
	localparam logic [3:0] FSS_RESET = 4'h0;
	localparam logic [3:0] FSS_MIN   = 4'h3;
	localparam logic [4:0] BITS_MIN  = 5'h04;
	localparam int Q_DEPTH = 8;
	localparam int Q_AW    = 3;
	localparam logic [Q_AW:0] Q_FULL = 4'h8;
	localparam int CLK_NS       = 10;
	localparam int SCLK_HALF_NS = 60;
	localparam int SCLK_HALF_CYC =
		(SCLK_HALF_NS / CLK_NS) < 1 ? 1 : SCLK_HALF_NS / CLK_NS;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {SPC_IDLE, SPC_RUN, SPC_END} spc_eng_e;

	typedef struct packed {
		logic                       aw_got;
		logic                       awready;
		logic                       w_got;
		logic                       wready;
		logic                       bvalid;
		logic [1:0]                 bresp;
		logic [31:0]                waddr;
		logic [15:0]                wdata;
		logic [1:0]                 wstrb;
		logic                       arready;
		logic                       rvalid;
		logic [1:0]                 rresp;
		logic [31:0]                rdata;
		logic [3:0]                 fss;
		logic                       loop;
		logic                       en;
		logic                       role;
		logic                       sob;
		logic [Q_DEPTH-1:0][15:0]   txq;
		logic [Q_AW-1:0]            tx_rd;
		logic [Q_AW-1:0]            tx_wr;
		logic [Q_AW:0]              tx_cnt;
		logic [Q_DEPTH-1:0][15:0]   rxq;
		logic [Q_AW-1:0]            rx_rd;
		logic [Q_AW-1:0]            rx_wr;
		logic [Q_AW:0]              rx_cnt;
		spc_eng_e                   eng;
		logic [15:0]                shreg;
		logic [15:0]                rxsh;
		logic [4:0]                 bitcnt;
		logic [7:0]                 div;
		logic                       sclk;
		logic                       ssel;
		logic                       mosi;
		logic                       miso;
		logic                       sclk_oe;
		logic                       ssel_oe;
		logic                       mosi_oe;
		logic                       miso_oe;
		logic [2:0]                 sclk_s;
		logic [1:0]                 ssel_s;
		logic [1:0]                 mosi_s;
		logic [1:0]                 miso_s;
	} spc_state_s;
endpackage

// ### dv/spc_peer.sv
// Far-side serial partner: slave for master tests, master for slave tests
`timescale 1ns/100ps
module spc_peer (
	input  wire logic sclk_i,
	input  wire logic ssel_b_i,
	input  wire logic mosi_i,
	input  wire logic miso_i,
	output logic      sclk_o,
	output logic      ssel_b_o,
	output logic      mosi_o,
	output logic      miso_o
);
	logic        mst = 0;
	logic [15:0] tx = 16'h000f;
	logic [15:0] sh = 16'h0000;
	logic [15:0] rx = 16'h0000;
	int          nb = 4;
	initial begin
		sclk_o = 0;
		ssel_b_o = 1;
		mosi_o = 0;
		miso_o = 0;
	end
	always @(negedge ssel_b_i) begin
		rx = 16'h0000;
		if (!mst) begin
			sh = tx << (16 - nb);
			miso_o = sh[15];
		end
	end
	always @(posedge sclk_i)
		if (!ssel_b_i)
			rx = {rx[14:0], mst ? miso_i : mosi_i};
	always @(negedge sclk_i)
		if (!ssel_b_i && !mst) begin
			sh = sh << 1;
			miso_o = sh[15];
		end
	// No pull on the line, so a released bit shows its opposite
	always @(posedge ssel_b_i)
		if (!mst)
			miso_o = !miso_o;
	// Clock runs only inside the frame, 125 ns period, idle low
	task automatic xfer(input logic [15:0] w, input int n);
		mst = 1;
		sh = w << (16 - n);
		mosi_o = sh[15];
		ssel_b_o = 0;
		repeat (n) begin
			#62.5 sclk_o = 1;
			#62.5 sclk_o = 0;
			sh = sh << 1;
			mosi_o = sh[15];
		end
		#62.5 ssel_b_o = 1;
		mosi_o = !mosi_o;
		#200 mst = 0;
	endtask
endmodule // spc_peer

// ### dv/spc_port_tb.sv
// Self-checking bench for the serial port controller
`timescale 1ns/100ps
module spc_port_tb
	import spc_pkg::*;
;
	logic        clk_sys_i = 0;
	logic        rst_b_i = 0;
	logic [31:0] s_axi_awaddr_i = 0;
	logic        s_axi_awvalid_i = 0;
	logic        s_axi_awready_o;
	logic [31:0] s_axi_wdata_i = 0;
	logic [3:0]  s_axi_wstrb_i = 4'hf;
	logic        s_axi_wvalid_i = 0;
	logic        s_axi_wready_o;
	logic [1:0]  s_axi_bresp_o;
	logic        s_axi_bvalid_o;
	logic        s_axi_bready_i = 0;
	logic [31:0] s_axi_araddr_i = 0;
	logic        s_axi_arvalid_i = 0;
	logic        s_axi_arready_o;
	logic [31:0] s_axi_rdata_o;
	logic [1:0]  s_axi_rresp_o;
	logic        s_axi_rvalid_o;
	logic        s_axi_rready_i = 0;
	logic        sclk_o, sclk_oe_o, ssel_b_o, ssel_b_oe_o;
	logic        mosi_o, mosi_oe_o, miso_o, miso_oe_o;
	logic        p_sclk, p_ssel_b, p_mosi, p_miso;
	wire logic   sclk_i = sclk_oe_o ? sclk_o : p_sclk;
	wire logic   ssel_b_i = ssel_b_oe_o ? ssel_b_o : p_ssel_b;
	wire logic   mosi_i = mosi_oe_o ? mosi_o : p_mosi;
	// Released MISO shows the inverse of what the port would send
	wire logic   miso_i = miso_oe_o ? miso_o :
		(u_spc_peer.mst ? !miso_o : p_miso);
	logic [31:0] v;
	logic [1:0]  resp;
	logic [3:0]  seen = 0;
	logic        seen_clr = 0;
	int          n_fail = 0;
	int          comparisons = 0;
	int          i;

	spc_port #(.HALF_CYC(6)) u_spc_port (.clk_sys_i, .rst_b_i,
		.s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
		.s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
		.s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
		.s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
		.s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
		.sclk_i, .sclk_o, .sclk_oe_o, .ssel_b_i, .ssel_b_o, .ssel_b_oe_o,
		.mosi_i, .mosi_o, .mosi_oe_o, .miso_i, .miso_o, .miso_oe_o);
	spc_peer u_spc_peer (.sclk_i, .ssel_b_i, .mosi_i, .miso_i,
		.sclk_o(p_sclk), .ssel_b_o(p_ssel_b), .mosi_o(p_mosi),
		.miso_o(p_miso));

	always #5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i)
		seen <= seen_clr ? 4'h0 :
			seen | {sclk_oe_o, ssel_b_oe_o, mosi_oe_o, miso_oe_o};

	task automatic stop_test;
		if (n_fail == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic wr(input logic [31:0] a, d);
		@(posedge clk_sys_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1;
		s_axi_wvalid_i <= 1;
		s_axi_bready_i <= 1;
		fork
			begin
				do @(posedge clk_sys_i); while (!s_axi_awready_o);
				s_axi_awvalid_i <= 0;
			end
			begin
				do @(posedge clk_sys_i); while (!s_axi_wready_o);
				s_axi_wvalid_i <= 0;
			end
		join
		do @(posedge clk_sys_i); while (!s_axi_bvalid_o);
		resp = s_axi_bresp_o;
		s_axi_bready_i <= 0;
	endtask
	task automatic rd(input logic [31:0] a);
		@(posedge clk_sys_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1;
		s_axi_rready_i <= 1;
		do @(posedge clk_sys_i); while (!s_axi_arready_o);
		s_axi_arvalid_i <= 0;
		do @(posedge clk_sys_i); while (!s_axi_rvalid_o);
		v = s_axi_rdata_o;
		resp = s_axi_rresp_o;
		s_axi_rready_i <= 0;
	endtask
	task automatic rdc(input string n, input logic [31:0] a, exp);
		rd(a);
		chk(n, v, exp);
	endtask
	task automatic wait_idle;
		do rd(PORT_STATUS_ADDR); while (v[ST_BUSY] !== 1'b0);
	endtask
	task automatic clr_seen;
		@(posedge clk_sys_i);
		seen_clr <= 1;
		@(posedge clk_sys_i);
		seen_clr <= 0;
		@(negedge clk_sys_i);
	endtask

	task automatic t_reset;
		rd(PORT_CONTROL_ADDR);
		chk("control", v[3:0], 4'h0); // off at reset
		chk("rresp ok", resp, RESP_OKAY);
		rdc("config", FRAME_CONFIG_ADDR, 0); // size code
		rdc("status", PORT_STATUS_ADDR, 32'h3); // flags
		rdc("unmapped", 32'h4004_0020, 0);
		chk("rresp", resp, RESP_SLVERR);
		wr(32'h4004_0020, 1);
		chk("bresp", resp, RESP_SLVERR);
	endtask
	task automatic t_role;
		wr(PORT_CONTROL_ADDR, 32'h2);
		chk("bresp ok", resp, RESP_OKAY);
		wr(PORT_CONTROL_ADDR, 32'h6);
		rd(PORT_CONTROL_ADDR);
		chk("role kept", v[3:0], 4'h2); // locked
		wr(PORT_CONTROL_ADDR, 32'h0);
		wr(PORT_CONTROL_ADDR, 32'h4);
		rd(PORT_CONTROL_ADDR);
		chk("role set", v[3:0], 4'h4); // free
		wr(PORT_CONTROL_ADDR, 32'h0);
	endtask
	// Fill while off; room is checked before every push
	task automatic t_queue;
		clr_seen;
		for (i = 0; i < 8; i++) begin
			rd(PORT_STATUS_ADDR);
			chk("tx room", v[ST_TX_ROOM], 1); // room first
			wr(DATA_PORT_ADDR, 32'hfff0 | i);
		end
		rd(PORT_STATUS_ADDR);
		chk("tx room", v[ST_TX_ROOM], 0); // full
		chk("bus off", seen, 0); // silent
		wr(PORT_CONTROL_ADDR, 32'h1);
		wr(PORT_CONTROL_ADDR, 32'h3); // config first
		wait_idle;
		rd(PORT_STATUS_ADDR);
		chk("rx entry", v[ST_RX_ENTRY], 1); // waiting
		for (i = 0; i < 8; i++)
			rdc("rx order", DATA_PORT_ADDR, i);
		rd(PORT_STATUS_ADDR);
		chk("rx entry", v[ST_RX_ENTRY], 0); // drained
		wr(PORT_CONTROL_ADDR, 32'h0);
	endtask
	task automatic t_master;
		u_spc_peer.tx = 16'h00c5;
		u_spc_peer.nb = 8;
		wr(FRAME_CONFIG_ADDR, 32'h7);
		// block bit set first, no effect in master
		wr(PORT_CONTROL_ADDR, 32'h8);
		wr(PORT_CONTROL_ADDR, 32'ha);
		wr(DATA_PORT_ADDR, 32'h3a); // room, aligned
		repeat (2) @(posedge clk_sys_i);
		chk("select", {ssel_b_oe_o, ssel_b_o}, 2'b10); // at once
		wait_idle;
		rdc("master rx", DATA_PORT_ADDR, 32'hc5);
		chk("peer rx", u_spc_peer.rx, 16'h3a); // mosi
		wr(PORT_CONTROL_ADDR, 32'h0);
	endtask
	task automatic t_slave;
		wr(PORT_CONTROL_ADDR, 32'h4);
		wr(PORT_CONTROL_ADDR, 32'h6);
		wr(DATA_PORT_ADDR, 32'h5a);
		clr_seen;
		u_spc_peer.xfer(16'h00c3, 8);
		repeat (4) @(posedge clk_sys_i);
		rdc("slave rx", DATA_PORT_ADDR, 32'hc3);
		chk("peer rx", u_spc_peer.rx, 16'h5a); // miso
		chk("drives", seen, 4'b0001); // only miso
		wr(PORT_CONTROL_ADDR, 32'hc);
		wr(PORT_CONTROL_ADDR, 32'he);
		clr_seen;
		u_spc_peer.xfer(16'h003c, 8);
		repeat (4) @(posedge clk_sys_i);
		rdc("slave rx", DATA_PORT_ADDR, 32'h3c); // still receives
		chk("blocked", seen, 0); // no drive
		chk("released miso", u_spc_peer.rx, 16'h00ff); // line free
		wr(PORT_CONTROL_ADDR, 32'h0);
	endtask

	// Whole run is well under two thousand cycles; this leaves ample margin
	initial begin
		#200us;
		n_fail++;
		stop_test;
	end
	initial begin
		repeat (8) @(posedge clk_sys_i);
		rst_b_i <= 1;
		t_reset;
		t_role;
		t_queue;
		t_master;
		t_slave;
		stop_test;
	end
endmodule // spc_port_tb
